//--- bench/testbench.sv
// Purpose: self-checking bench for the core datapath state block
// Assumes: bus answers when hreadyout is sampled high; ops execute on valid edges
// Notes: pcl add/sub checks look only at the page, the low byte timing is a design choice
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, w) begin cmp_count++; if ((g) !== (w)) begin num_errors++; $display("unexpected at %0t: got %h want %h", $time, (g), (w)); end end
module testbench;
	import core_pkg::*;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, irq_entry = 0, hready, hreadyout, hresp;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [1:0] htrans = 0, reset_cause_in = 0;
	logic [2:0] hsize = 0;
	logic rw = 1; // target read/write marker for the next op
	op_t op = '0;
	logic [7:0] accumulator_reg, hl_bank, hl_loc;
	logic [11:0] instruction_pointer;
	mem_wr_t mem_wr;
	int num_errors = 0, cmp_count = 0;
	assign hready = hreadyout; // single slave drives the bus ready
	always #4 hclk = ~hclk;
	cpu_core_pc_flags_regs cpu_core_pc_flags_regs_inst (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .op(op), .irq_entry(irq_entry), .reset_cause_in(reset_cause_in),
		.accumulator_reg(accumulator_reg), .instruction_pointer(instruction_pointer),
		.hl_bank(hl_bank), .hl_loc(hl_loc), .mem_wr(mem_wr));
	////////////////////////////////////////////////////////////////////////////////
	// one single transfer; values read right after an edge are the sampled ones
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
		int n;
		hsel <= 1; htrans <= HTRANS_NONSEQ; haddr <= a; hwrite <= w; hsize <= HSIZE_WORD;
		n = 0;
		do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
		htrans <= 2'h0; hwdata <= wd;
		do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
		rd = hrdata;
		hsel <= 0;
		if (n >= 100) num_errors++;
		#1;
		`CHK(hresp, HRESP_OKAY)
	endtask : bus
	// one instruction; memory target 0x10 unless told otherwise
	task automatic op1(input op_code_t c, input logic [7:0] v, input logic [7:0] a = 8'h10,
		input logic [11:0] d = 12'h000);
		op_t o;
		o = '0; o.valid = 1; o.code = c; o.addr = a; o.mem_data = v; o.imm = v;
		o.bit_sel = 3'h3; o.target_rw = rw; o.dest = d;
		op <= o;
		@(posedge hclk);
		op <= '0;
		#1;
	endtask : op1
	task automatic sk(input op_code_t c, input logic [7:0] v, input logic [11:0] e);
		op1(c, v);
		`CHK(instruction_pointer, e)
	endtask : sk
	task automatic flags(input logic [7:0] e);
		bus(0, 32'h218, 0);
		`CHK(rd, {24'h0, e})
	endtask : flags
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		for (int c = 0; c < 4; c++) begin
			@(posedge hclk);
			hresetn <= 0; reset_cause_in <= c[1:0];
			repeat (10) @(posedge hclk);
			hresetn <= 1;
			@(posedge hclk); #1;
			`CHK(instruction_pointer, PC_RST)
			`CHK(hreadyout, 1'b1)
			flags({c[1:0], 6'h00});
		end
		$display("reset test done");
	endtask : t_reset
	task automatic t_alu;
		op1(OP_LOAD_A, 8'h9c);
		op1(OP_ADD_A, 8'h64);
		`CHK(accumulator_reg, 8'h00)
		`CHK(instruction_pointer, 12'h002)
		flags(8'hc7);
		op1(OP_SUB_A, 8'h01);
		flags(8'hc0);
		op1(OP_RLC_A, 8'h00);
		`CHK(accumulator_reg, 8'hfe)
		op1(OP_LOAD_A, 8'h00);
		flags(8'hc5);
		op1(OP_ADC_A, 8'h01);
		`CHK(accumulator_reg, 8'h02)
		flags(8'hc0);
		$display("alu test done");
	endtask : t_alu
	task automatic t_skip;
		op1(OP_JMP, 8'h00, 8'h10, 12'h100);
		sk(OP_LOAD_A, 8'h12, 12'h101);
		sk(OP_COMPARE_SKIP_OP, 8'h12, 12'h103);
		sk(OP_COMPARE_SKIP_OP, 8'h13, 12'h104);
		sk(OP_INC_SKIP_ACC_OP, 8'hff, 12'h106);
		sk(OP_INC_SKIP_ACC_OP, 8'h10, 12'h107);
		sk(OP_DEC_SKIP_ACC_OP, 8'h00, 12'h109);
		sk(OP_DEC_SKIP_MEM_OP, 8'h05, 12'h10a);
		sk(OP_INC_SKIP_MEM_OP, 8'hff, 12'h10c);
		sk(OP_BIT_SET_SKIP_OP, 8'h08, 12'h10e);
		sk(OP_BIT_CLEAR_SKIP_OP, 8'h08, 12'h10f);
		sk(OP_BANK0_BIT_CLEAR_SKIP_OP, 8'h00, 12'h111);
		sk(OP_BANK0_BIT_SET_SKIP_OP, 8'h00, 12'h112);
		$display("skip test done");
	endtask : t_skip
	task automatic t_pc;
		op1(OP_JMP, 8'h00, 8'h10, 12'h3f0);
		`CHK(instruction_pointer, 12'h3f0)
		op1(OP_CALL, 8'h00, 8'h10, 12'h3f0);
		`CHK(instruction_pointer, 12'h3f0)
		op1(OP_LOAD_A, 8'h20);
		op1(OP_ADD_M, 8'h00, IDX_PCL);
		`CHK(instruction_pointer[11:8], 4'h4)
		op1(OP_SUB_M, 8'h00, IDX_PCL);
		`CHK(instruction_pointer[11:8], 4'h4)
		op1(OP_STORE_A, 8'h00, IDX_PCL);
		`CHK(instruction_pointer, 12'h420)
		bus(0, 32'h300, 0);
		`CHK(rd, 32'h420)
		$display("pc test done");
	endtask : t_pc
	task automatic t_regs;
		bus(1, 32'h200, 32'h5a);
		bus(1, 32'h204, 32'ha5);
		`CHK(hl_loc, 8'h5a)
		`CHK(hl_bank, 8'ha5)
		bus(0, 32'h200, 0);
		`CHK(rd, 32'h5a)
		bus(0, 32'h3fc, 0);
		`CHK(rd, 32'h0)
		rw = 0;
		op1(OP_BCLR, 8'h00, IDX_LOW_PTR);
		`CHK(hl_loc, 8'h5a)
		rw = 1;
		op1(OP_BCLR, 8'h00, IDX_LOW_PTR);
		`CHK(hl_loc, 8'h52)
		$display("register test done");
	endtask : t_regs
	task automatic t_save;
		op1(OP_LOAD_A, 8'h74);
		op1(OP_PUSH, 8'h00);
		op1(OP_LOAD_A, 8'h00);
		irq_entry <= 1;
		@(posedge hclk);
		irq_entry <= 0;
		#1;
		`CHK(accumulator_reg, 8'h00)
		op1(OP_POP, 8'h00);
		`CHK(accumulator_reg, 8'h74)
		bus(0, 32'h218, 0);
		`CHK(rd[7:6], CAUSE_PIN)
		$display("save test done");
	endtask : t_save
	////////////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		t_reset();
		t_alu();
		t_skip();
		t_pc();
		t_regs();
		t_save();
		tally_and_finish();
	end
	// hang guard, far beyond the roughly 125 cycles the tests need
	initial begin
		#100000;
		num_errors++;
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire

//--- hdl/core_pkg.sv
// Purpose: shared constants and carriers for the core datapath state block
// Assumes: 8-bit data path, 12-bit program counter, AHB-Lite register access
// Notes: indexes are word indexes; the bus byte address is four times the index
package core_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// widths
	localparam int DATA_W = 8; // accumulator and working registers
	localparam int PC_W = 12; // program counter
	localparam int PCH_W = 4; // high page of the program counter
	localparam int SAVE_W = 13; // accumulator plus five flag bits

	////////////////////////////////////////////////////////////////////////////////
	// register indexes (target codes and bus word indexes)
	localparam logic [7:0] IDX_LOW_PTR = 8'h80; // low_pointer_byte
	localparam logic [7:0] IDX_HIGH_PTR = 8'h81; // high_pointer_byte
	localparam logic [7:0] IDX_FLAGS = 8'h86; // status_flags
	localparam logic [7:0] IDX_PCL = 8'hce; // pointer_lower_byte
	localparam logic [7:0] IDX_PCH = 8'hcf; // pointer_upper_byte
	localparam logic [7:0] IDX_PC = 8'hc0; // whole instruction_pointer, bus only
	localparam int ADDR_IDX_LSB = 2; // word aligned decode
	localparam int ADDR_IDX_MSB = 9;

	////////////////////////////////////////////////////////////////////////////////
	// status_flags field positions and values
	localparam int FLAG_CAUSE_HI = 7; // reset_cause_hi
	localparam int FLAG_CAUSE_LO = 6; // reset_cause_lo
	localparam int FLAG_C = 2; // carry
	localparam int FLAG_DC = 1; // nibble_out_bit
	localparam int FLAG_Z = 0; // zero
	localparam logic [1:0] CAUSE_WDT = 2'h0; // watchdog timeout
	localparam logic [1:0] CAUSE_RSVD = 2'h1; // reserved
	localparam logic [1:0] CAUSE_LVD = 2'h2; // low_voltage_detect reset
	localparam logic [1:0] CAUSE_PIN = 2'h3; // external reset pin
	localparam logic ALU_FLAG_RST = 1'h0;

	////////////////////////////////////////////////////////////////////////////////
	// reset values and step sizes
	localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
	localparam logic [DATA_W-1:0] BYTE_ONE = 8'h01;
	localparam logic [DATA_W-1:0] BYTE_FULL = 8'hff;
	localparam logic [DATA_W-1:0] PTR_RST = 8'h00; // contents undefined, zero chosen
	localparam logic [PC_W-1:0] PC_RST = 12'h000;
	localparam logic [PC_W-1:0] PC_STEP = 12'h001;
	localparam logic [PC_W-1:0] PC_SKIP = 12'h002;
	localparam logic [PCH_W-1:0] PCH_ONE = 4'h1;

	////////////////////////////////////////////////////////////////////////////////
	// bus encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic HRESP_OKAY = 1'h0;

	////////////////////////////////////////////////////////////////////////////////
	// operations handed over by the instruction decoder
	typedef enum logic [25:0] {
		OP_LOAD_A = 26'h0000001, // a = src
		OP_STORE_A = 26'h0000002, // m = a
		OP_ADD_A = 26'h0000004, // a = a + src
		OP_ADC_A = 26'h0000008, // a = a + src + c
		OP_SUB_A = 26'h0000010, // a = a - src
		OP_AND_A = 26'h0000020, // a = a & src
		OP_ADD_M = 26'h0000040, // m = m + a
		OP_ADC_M = 26'h0000080, // m = m + a + c
		OP_BANK0_ADD_OP_M = 26'h0000100, // bank0 m = m + a
		OP_SUB_M = 26'h0000200, // m = m - a
		OP_RLC_A = 26'h0000400, // a = rotate left through carry
		OP_COMPARE_SKIP_OP = 26'h0000800, // compare_skip_op
		OP_INC_SKIP_ACC_OP = 26'h0001000, // inc_skip_acc_op
		OP_INC_SKIP_MEM_OP = 26'h0002000, // inc_skip_mem_op
		OP_DEC_SKIP_ACC_OP = 26'h0004000, // dec_skip_acc_op
		OP_DEC_SKIP_MEM_OP = 26'h0008000, // dec_skip_mem_op
		OP_BIT_CLEAR_SKIP_OP = 26'h0010000, // bit_clear_skip_op
		OP_BIT_SET_SKIP_OP = 26'h0020000, // bit_set_skip_op
		OP_BANK0_BIT_CLEAR_SKIP_OP = 26'h0040000, // bank0_bit_clear_skip_op
		OP_BANK0_BIT_SET_SKIP_OP = 26'h0080000, // bank0_bit_set_skip_op
		OP_BSET = 26'h0100000, // single bit set
		OP_BCLR = 26'h0200000, // single bit clear
		OP_JMP = 26'h0400000, // jump_op
		OP_CALL = 26'h0800000, // call
		OP_PUSH = 26'h1000000, // save a and flags
		OP_POP = 26'h2000000 // restore a and flags
	} op_code_t;

	typedef struct packed {
		logic valid; // one instruction executes this cycle
		op_code_t code;
		logic [7:0] addr; // memory or register target
		logic [DATA_W-1:0] mem_data; // memory operand read by the decoder
		logic imm_sel; // use imm instead of the target value
		logic [DATA_W-1:0] imm;
		logic [2:0] bit_sel;
		logic target_rw; // target is readable and writable
		logic [PC_W-1:0] dest; // jump or call destination
	} op_t;

	typedef struct packed {
		logic en;
		logic [7:0] addr;
		logic [DATA_W-1:0] data;
	} mem_wr_t;

endpackage : core_pkg

//--- hdl/cpu_core_pc_flags_regs.sv
// Purpose: accumulator, status flags, program counter and pointer pair of the core
// Assumes: decoder hands over one executed instruction per valid cycle
// Notes: bus accesses wait while instructions execute
//
// Contract
// - 8-bit accumulator, zero/carry into flags
// - accumulator has no data memory address
// - interrupt entry saves nothing automatically
// - save/restore ops copy accumulator and flags
// - flags hold cause 7:6, c dc z
// - cause codes watchdog, reserved, lvd, pin
// - carry set on carry, no borrow, shift-one
// - nibble carry on low nibble carry
// - zero flag follows result being zero
// - 12-bit counter, 4+8 split, resets zero
// - counter advances one per instruction
// - jump and call load destination address
// - true skip condition advances counter by two
// - bit test skips on matching bit value
// - compare skips when accumulator equals operand
// - increment skips on wrap to zero
// - decrement skips on wrap to full
// - adds into low byte carry into high
// - low byte borrow leaves high byte alone
// - low byte write jumps within page
// - pointer pair are plain read/write bytes
// - high pointer selects bank, low location
// - bit set/clear only on read/write targets
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module cpu_core_pc_flags_regs
	import core_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire op_t op,
	input wire logic irq_entry,
	input wire logic [1:0] reset_cause_in,
	output logic [DATA_W-1:0] accumulator_reg,
	output logic [PC_W-1:0] instruction_pointer,
	output logic [DATA_W-1:0] hl_bank,
	output logic [DATA_W-1:0] hl_loc,
	output mem_wr_t mem_wr
);

	////////////////////////////////////////////////////////////////////////////////
	// state
	logic [DATA_W-1:0] low_pointer_byte; // working byte, pointer location
	logic [DATA_W-1:0] high_pointer_byte; // working byte, pointer bank
	logic [1:0] cause; // reset cause pair
	logic cause_taken; // cause sampled once after release
	logic flag_c;
	logic flag_dc;
	logic flag_z;
	logic [SAVE_W-1:0] saved; // hidden buffer contents
	logic [DATA_W-1:0] status_flags; // assembled byte
	logic pend; // bus data phase waiting
	logic pend_write;
	logic pend_ok; // word sized transfer
	logic [7:0] pend_idx;

	////////////////////////////////////////////////////////////////////////////////
	// datapath results
	logic [DATA_W-1:0] tgt_val; // current value of the target
	logic [DATA_W-1:0] src; // operand after immediate select
	logic [DATA_W-1:0] res; // value written to the target
	logic [DATA_W-1:0] acc_val; // next accumulator value
	logic [DATA_W-1:0] bit_mask;
	logic [8:0] wide; // nine bit arithmetic result
	logic [4:0] nib; // low nibble arithmetic result
	logic acc_we;
	logic res_we;
	logic upd_c;
	logic upd_dc;
	logic upd_z;
	logic val_c;
	logic val_dc;
	logic skip;
	logic pch_carry; // carry from a low byte add
	logic cin;
	logic int_hit; // target lives inside this block
	logic bus_go; // bus access completes this cycle
	logic [DATA_W-1:0] saved_acc_q; // accumulator flop
	logic [PC_W-1:0] pc; // program counter flop

	assign status_flags = {cause, 3'h0, flag_c, flag_dc, flag_z};
	assign accumulator_reg = saved_acc_q;
	assign instruction_pointer = pc;
	assign hl_bank = high_pointer_byte;
	assign hl_loc = low_pointer_byte;
	assign bus_go = pend && !op.valid;
	assign cin = flag_c;

	////////////////////////////////////////////////////////////////////////////////
	// target read: no index maps to the accumulator
	always_comb begin
		int_hit = 1'b1;
		unique case (op.addr)
			IDX_LOW_PTR: tgt_val = low_pointer_byte;
			IDX_HIGH_PTR: tgt_val = high_pointer_byte;
			IDX_FLAGS: tgt_val = status_flags;
			IDX_PCL: tgt_val = pc[DATA_W-1:0];
			IDX_PCH: tgt_val = {4'h0, pc[PC_W-1:DATA_W]};
			default: begin
				tgt_val = op.mem_data;
				int_hit = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// alu and skip decision, each op names its own flags
	always_comb begin
		src = op.imm_sel ? op.imm : tgt_val;
		bit_mask = BYTE_ONE << op.bit_sel;
		res = BYTE_ZERO;
		acc_val = saved_acc_q;
		wide = 9'h000;
		nib = 5'h00;
		acc_we = 1'b0;
		res_we = 1'b0;
		upd_c = 1'b0;
		upd_dc = 1'b0;
		upd_z = 1'b0;
		val_c = 1'b0;
		val_dc = 1'b0;
		skip = 1'b0;
		pch_carry = 1'b0;
		unique case (op.code)
			OP_LOAD_A: begin
				acc_val = src;
				acc_we = 1'b1;
				upd_z = 1'b1;
			end
			OP_STORE_A: begin
				res = saved_acc_q;
				res_we = 1'b1;
			end
			OP_ADD_A, OP_ADC_A, OP_ADD_M, OP_ADC_M, OP_BANK0_ADD_OP_M: begin
				wide = {1'b0, saved_acc_q} + {1'b0, src}
					+ {8'h00, cin && (op.code == OP_ADC_A || op.code == OP_ADC_M)};
				nib = {1'b0, saved_acc_q[3:0]} + {1'b0, src[3:0]}
					+ {4'h0, cin && (op.code == OP_ADC_A || op.code == OP_ADC_M)};
				val_c = wide[8];
				val_dc = nib[4];
				upd_c = 1'b1;
				upd_dc = 1'b1;
				upd_z = 1'b1;
				pch_carry = wide[8];
				acc_we = (op.code == OP_ADD_A || op.code == OP_ADC_A);
				acc_val = wide[DATA_W-1:0];
				res_we = !acc_we;
				res = wide[DATA_W-1:0];
			end
			OP_SUB_A, OP_SUB_M, OP_COMPARE_SKIP_OP: begin
				// a - src for the accumulator forms, m - a for the memory form
				wide = (op.code == OP_SUB_M) ? ({1'b0, src} - {1'b0, saved_acc_q})
					: ({1'b0, saved_acc_q} - {1'b0, src});
				nib = (op.code == OP_SUB_M) ? ({1'b0, src[3:0]} - {1'b0, saved_acc_q[3:0]})
					: ({1'b0, saved_acc_q[3:0]} - {1'b0, src[3:0]});
				val_c = !wide[8];
				val_dc = !nib[4];
				upd_c = 1'b1;
				upd_dc = (op.code != OP_COMPARE_SKIP_OP);
				upd_z = 1'b1;
				skip = (op.code == OP_COMPARE_SKIP_OP) && (saved_acc_q == src);
				acc_we = (op.code == OP_SUB_A);
				acc_val = wide[DATA_W-1:0];
				res_we = (op.code == OP_SUB_M); // borrow never reaches the page
				res = wide[DATA_W-1:0];
			end
			OP_AND_A: begin
				acc_val = saved_acc_q & src;
				acc_we = 1'b1;
				upd_z = 1'b1;
			end
			OP_RLC_A: begin
				acc_val = {saved_acc_q[DATA_W-2:0], cin};
				acc_we = 1'b1;
				val_c = saved_acc_q[DATA_W-1];
				upd_c = 1'b1;
			end
			OP_INC_SKIP_ACC_OP, OP_INC_SKIP_MEM_OP: begin
				res = src + BYTE_ONE;
				skip = (src == BYTE_FULL);
				acc_we = (op.code == OP_INC_SKIP_ACC_OP);
				acc_val = res;
				res_we = (op.code == OP_INC_SKIP_MEM_OP);
			end
			OP_DEC_SKIP_ACC_OP, OP_DEC_SKIP_MEM_OP: begin
				res = src - BYTE_ONE;
				skip = (src == BYTE_ZERO);
				acc_we = (op.code == OP_DEC_SKIP_ACC_OP);
				acc_val = res;
				res_we = (op.code == OP_DEC_SKIP_MEM_OP);
			end
			OP_BIT_CLEAR_SKIP_OP, OP_BANK0_BIT_CLEAR_SKIP_OP: begin
				skip = !src[op.bit_sel];
			end
			OP_BIT_SET_SKIP_OP, OP_BANK0_BIT_SET_SKIP_OP: begin
				skip = src[op.bit_sel];
			end
			OP_BSET, OP_BCLR: begin
				res = (op.code == OP_BSET) ? (tgt_val | bit_mask) : (tgt_val & ~bit_mask);
				res_we = op.target_rw;
			end
			default: begin
				// jump, call, save, restore and illegal codes change no data
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// hidden save buffer, loaded by the save op only
	save_buffer #(
		.WIDTH(SAVE_W)
	) u_save (
		.hclk(hclk),
		.hresetn(hresetn),
		.wr_en(op.valid && op.code == OP_PUSH),
		.wr_data({saved_acc_q, status_flags[FLAG_CAUSE_HI:FLAG_CAUSE_LO], flag_c, flag_dc,
			flag_z}),
		.rd_data(saved)
	);

	////////////////////////////////////////////////////////////////////////////////
	// accumulator: interrupt entry leaves it alone
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			saved_acc_q <= BYTE_ZERO;
		end else if (op.valid && op.code == OP_POP) begin
			saved_acc_q <= saved[SAVE_W-1:SAVE_W-DATA_W];
		end else if (op.valid && acc_we) begin
			saved_acc_q <= acc_val;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// alu flags: explicit writes beat computed updates
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag_c <= ALU_FLAG_RST;
			flag_dc <= ALU_FLAG_RST;
			flag_z <= ALU_FLAG_RST;
		end else if (op.valid && op.code == OP_POP) begin
			flag_c <= saved[FLAG_C];
			flag_dc <= saved[FLAG_DC];
			flag_z <= saved[FLAG_Z];
		end else if (op.valid && res_we && op.addr == IDX_FLAGS) begin
			flag_c <= res[FLAG_C];
			flag_dc <= res[FLAG_DC];
			flag_z <= res[FLAG_Z];
		end else if (op.valid) begin
			if (upd_c) begin
				flag_c <= val_c;
			end
			if (upd_dc) begin
				flag_dc <= val_dc;
			end
			if (upd_z) begin
				flag_z <= acc_we ? (acc_val == BYTE_ZERO) : (wide[DATA_W-1:0] == BYTE_ZERO);
			end
		end else if (bus_go && pend_write && pend_ok && pend_idx == IDX_FLAGS) begin
			flag_c <= hwdata[FLAG_C];
			flag_dc <= hwdata[FLAG_DC];
			flag_z <= hwdata[FLAG_Z];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// reset cause: constant under reset, strap caught once after release
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cause <= CAUSE_PIN;
			cause_taken <= 1'b0;
		end else if (!cause_taken) begin
			cause <= reset_cause_in;
			cause_taken <= 1'b1;
		end else if (op.valid && op.code == OP_POP) begin
			// cause pair sits just above the three alu flags in the saved word
			cause <= saved[FLAG_C+2:FLAG_C+1];
		end else if (op.valid && res_we && op.addr == IDX_FLAGS) begin
			cause <= res[FLAG_CAUSE_HI:FLAG_CAUSE_LO];
		end else if (bus_go && pend_write && pend_ok && pend_idx == IDX_FLAGS) begin
			cause <= hwdata[FLAG_CAUSE_HI:FLAG_CAUSE_LO];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pointer pair: plain working bytes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			low_pointer_byte <= PTR_RST;
			high_pointer_byte <= PTR_RST;
		end else if (op.valid && res_we) begin
			if (op.addr == IDX_LOW_PTR) begin
				low_pointer_byte <= res;
			end
			if (op.addr == IDX_HIGH_PTR) begin
				high_pointer_byte <= res;
			end
		end else if (bus_go && pend_write && pend_ok) begin
			if (pend_idx == IDX_LOW_PTR) begin
				low_pointer_byte <= hwdata[DATA_W-1:0];
			end
			if (pend_idx == IDX_HIGH_PTR) begin
				high_pointer_byte <= hwdata[DATA_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// program counter
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pc <= PC_RST;
		end else if (op.valid) begin
			if (op.code == OP_JMP || op.code == OP_CALL) begin
				pc <= op.dest;
			end else if (res_we && op.addr == IDX_PCL) begin
				// page follows only an upward carry
				pc <= {pc[PC_W-1:DATA_W] + (pch_carry ? PCH_ONE : 4'h0), res};
			end else if (res_we && op.addr == IDX_PCH) begin
				pc <= {res[PCH_W-1:0], pc[DATA_W-1:0]} + PC_STEP;
			end else if (skip) begin
				pc <= pc + PC_SKIP;
			end else begin
				pc <= pc + PC_STEP;
			end
		end else if (bus_go && pend_write && pend_ok && pend_idx == IDX_PC) begin
			pc <= hwdata[PC_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// external memory writes for targets outside this block
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mem_wr <= '0;
		end else begin
			mem_wr.en <= op.valid && res_we && !int_hit;
			mem_wr.addr <= op.addr;
			mem_wr.data <= res;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// ahb-lite slave: one wait state at least, more while instructions run
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend <= 1'b0;
			pend_write <= 1'b0;
			pend_ok <= 1'b0;
			pend_idx <= 8'h00;
			hreadyout <= 1'b1;
			hrdata <= 32'h00000000;
			hresp <= HRESP_OKAY;
		end else if (hsel && hready && htrans == HTRANS_NONSEQ) begin
			pend <= 1'b1;
			pend_write <= hwrite;
			pend_ok <= (hsize == HSIZE_WORD);
			pend_idx <= haddr[ADDR_IDX_MSB:ADDR_IDX_LSB];
			hreadyout <= 1'b0;
		end else if (bus_go) begin
			pend <= 1'b0;
			hreadyout <= 1'b1;
			// unmapped reads return zero; narrow reads of mapped registers return their value
			unique case (pend_idx)
				IDX_LOW_PTR: hrdata <= {24'h000000, low_pointer_byte};
				IDX_HIGH_PTR: hrdata <= {24'h000000, high_pointer_byte};
				IDX_FLAGS: hrdata <= {24'h000000, status_flags};
				IDX_PC: hrdata <= {20'h00000, pc};
				default: hrdata <= 32'h00000000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	chk_acc_irq_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		irq_entry && !op.valid |=> saved_acc_q == $past(saved_acc_q))
		else $error("accumulator moved on interrupt entry");
	chk_pc_single_step: assert property (@(posedge hclk) disable iff (!hresetn)
		op.valid && op.code == OP_LOAD_A |=> pc == $past(pc) + PC_STEP)
		else $error("counter did not advance by one");
	chk_jump_dest: assert property (@(posedge hclk) disable iff (!hresetn)
		op.valid && op.code == OP_JMP |=> pc == $past(op.dest))
		else $error("jump destination not loaded");
	chk_cmp_skip_two: assert property (@(posedge hclk) disable iff (!hresetn)
		op.valid && op.code == OP_COMPARE_SKIP_OP && saved_acc_q == src |=> pc == $past(pc) + PC_SKIP)
		else $error("compare skip did not skip");
	chk_inc_wrap_skip: assert property (@(posedge hclk) disable iff (!hresetn)
		op.valid && op.code == OP_INC_SKIP_MEM_OP && src != BYTE_FULL && !(res_we && int_hit)
		|=> pc == $past(pc) + PC_STEP)
		else $error("increment skipped without wrap");
	chk_pcl_carry_up: assert property (@(posedge hclk) disable iff (!hresetn)
		op.valid && op.code == OP_BANK0_ADD_OP_M && op.addr == IDX_PCL && pch_carry
		|=> pc[PC_W-1:DATA_W] == $past(pc[PC_W-1:DATA_W]) + PCH_ONE)
		else $error("page not incremented on low byte carry");
	chk_pcl_borrow_keep: assert property (@(posedge hclk) disable iff (!hresetn)
		op.valid && op.code == OP_SUB_M && op.addr == IDX_PCL
		|=> pc[PC_W-1:DATA_W] == $past(pc[PC_W-1:DATA_W]))
		else $error("page changed on low byte borrow");
	chk_cmp_carry: assert property (@(posedge hclk) disable iff (!hresetn)
		op.valid && op.code == OP_COMPARE_SKIP_OP |=> flag_c == ($past(saved_acc_q) >= $past(src)))
		else $error("compare carry wrong");
	chk_bit_rw_only: assert property (@(posedge hclk) disable iff (!hresetn)
		op.valid && op.code == OP_BSET && !op.target_rw |=> !mem_wr.en)
		else $error("bit set reached a non read/write target");
	chk_bus_wait: assert property (@(posedge hclk) disable iff (!hresetn)
		hsel && hready && htrans == HTRANS_NONSEQ |=> !hreadyout ##1 (hreadyout || op.valid))
		else $error("bus answered without a wait state");

endmodule : cpu_core_pc_flags_regs
`default_nettype wire

//--- hdl/save_buffer.sv
// Purpose: hidden buffer holding the accumulator and flags across a service routine
// Assumes: one word deep, written by the save operation only
// Notes: read data come from a register and follow a write by one cycle
`timescale 1ns/100ps
`default_nettype none
module save_buffer #(
	parameter int WIDTH = 13
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic wr_en,
	input wire logic [WIDTH-1:0] wr_data,
	output logic [WIDTH-1:0] rd_data
);

	////////////////////////////////////////////////////////////////////////////////
	// storage word doubles as the read register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_data <= '0;
		end else if (wr_en) begin
			rd_data <= wr_data;
		end
	end

endmodule : save_buffer
`default_nettype wire
